// >>> src/tdm_switch_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the switch.
  Assumes a 200 MHz system clock and word-indexed Avalon-MM addresses.
*/
`ifndef TDM_SWITCH_DEFS_SVH
`define TDM_SWITCH_DEFS_SVH

// ----------------------------------------------------------------------
// Register space (address bit 13 low)
// ----------------------------------------------------------------------
`define CTRL_ADDR     14'h0000
`define FAR_ADDR      14'h0001
`define IOFF_BASE     14'h0002
`define OOFF_BASE     14'h000A
`define CTRL_RST      16'h0000
`define CTRL_MS_BIT   3
`define CTRL_SFE_BIT  8
`define CTRL_EVS_LSB  11
`define FAR_HALF_BIT  9
`define FAR_CFE_BIT   10

// ----------------------------------------------------------------------
// Connection memory word fields
// ----------------------------------------------------------------------
`define CM_ST_LSB     8
`define CM_MLO_BIT    13
`define CM_MHI_BIT    14

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ       200
`define ADV_STEP_NS   15
`define ADV_STEP_CYC  ((`ADV_STEP_NS * `CLK_MHZ) / 1000)
`define ADV_MAX_CODE  3
`define IN_MAX_CODE   9
`define CH_AT_2M      32
`define WR_BIT        3'h6
`define SQ_BIT        3'h4
`define PRBS_SEED     15'h7FFF

`endif

// >>> src/tdm_switch_pkg.sv
/*
  Types shared by the switch and its testbench.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tdm_switch_pkg;

  // --------------------------------------------------------------------
  // Frame evaluation states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    EV_IDLE = 2'b00,
    EV_WAIT = 2'b01,
    EV_CNT  = 2'b10,
    EV_DONE = 2'b11
  } eval_state_t;

  // --------------------------------------------------------------------
  // Per-channel modes, {chan_mode_hi, chan_mode_lo}
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_VAR   = 2'b00,
    MODE_MSG   = 2'b01,
    MODE_CONST = 2'b10,
    MODE_BERT  = 2'b11
  } chan_mode_t;

endpackage : tdm_switch_pkg

// >>> src/serial_lane.sv
/*
  One serial input stream and one serial output stream with their own
  sampling delay and output advance, each a tap on a tick delay line.
  Assumes ticks from the parent timers and an already synchronised input.
*/
`timescale 1ns/1ps
module serial_lane #(
  parameter int DMAX = 32
) (
  // Clock and reset.
  input  logic                      clk,
  input  logic                      reset_n,
  // Input side.
  input  logic                      in_tick,
  input  logic                      in_last,
  input  logic [$clog2(DMAX)-1:0]   in_dly,
  input  logic                      sin,
  output logic [7:0]                in_byte,
  // Output side.
  input  logic                      out_tick,
  input  logic                      out_first,
  input  logic [$clog2(DMAX)-1:0]   out_dly,
  input  logic [7:0]                out_byte,
  output logic                      sout
);

  localparam int DW = $clog2(DMAX);

  typedef struct packed {
    logic [DMAX-1:0] itk;
    logic [DMAX-1:0] ilst;
    logic [DMAX-1:0] otk;
    logic [DMAX-1:0] ofst;
    logic [7:0]      ish;
    logic [7:0]      ibyte;
    logic [7:0]      osh;
    logic            sout;
  } lane_st_t;

  lane_st_t s;
  lane_st_t n;
  logic     itk_d;
  logic     ilst_d;
  logic     otk_d;
  logic     ofst_d;

  // ----------------------------------------------------------------------
  // Delay taps and shifting
  // ----------------------------------------------------------------------
  always_comb begin
    n = s;
    n.itk  = {s.itk[DMAX-2:0], in_tick};
    n.ilst = {s.ilst[DMAX-2:0], in_last};
    n.otk  = {s.otk[DMAX-2:0], out_tick};
    n.ofst = {s.ofst[DMAX-2:0], out_first};
    itk_d  = (in_dly == '0) ? in_tick : s.itk[DW'(in_dly - 1'b1)];
    ilst_d = (in_dly == '0) ? in_last : s.ilst[DW'(in_dly - 1'b1)];
    otk_d  = (out_dly == '0) ? out_tick : s.otk[DW'(out_dly - 1'b1)];
    ofst_d = (out_dly == '0) ? out_first : s.ofst[DW'(out_dly - 1'b1)];
    if (itk_d) begin
      n.ish = {s.ish[6:0], sin};
      if (ilst_d) n.ibyte = {s.ish[6:0], sin};
    end
    if (otk_d) begin
      if (ofst_d) begin
        n.sout = out_byte[7];
        n.osh  = {out_byte[6:0], 1'b0};
      end else begin
        n.sout = s.osh[7];
        n.osh  = {s.osh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) s <= '0;
    else          s <= n;
  end

  assign in_byte = s.ibyte;
  assign sout    = s.sout;

endmodule : serial_lane

// >>> src/tdm_switch.sv
/*
  Time-division switch core: serial stream timing, data and connection
  memories, frame offset measurement and an Avalon-MM register slave.
  Assumes frame_pulse and serial inputs are asynchronous pins and that
  the host reads data memory twice for a valid result.
*/
// Behaviour
// - Measured offset reported in nine-bit delay field.
// - Falling start bit clears measured delay field.
// - Input offset code delays sampling half-clock steps.
// - Output advance code shifts output 15 ns steps.
// - Advance only in 8/16-based rate modes.
// - Data memory read valid on second read.
// - Address bit 13 low selects registers.
// - Bit 13 high: memory_select picks data/connection.
// - Address 12..8 stream, 7..0 channel.
// - Connection word per output channel, two mode bits.
// - Variable/constant modes switch stored source timeslot.
// - Message mode sends low connection byte.
// - Test mode sends pseudo-random pattern.
// - Start bit rise begins measurement, completion stops.
// - Rate select picks one of seven modes.
`timescale 1ns/1ps
`include "tdm_switch_defs.svh"
module tdm_switch
  import tdm_switch_pkg::*;
#(
  parameter int NSTREAM       = 32,
  parameter int NCHAN         = 256,
  parameter int BIT16_CYC     = 12,
  parameter int MCLK_HALF_CYC = 3,
  parameter int DMAX          = 32
) (
  // Clock and reset.
  input  logic                 clk,
  input  logic                 reset_n,
  // Avalon-MM slave.
  input  logic [13:0]          avs_address,
  input  logic                 avs_read,
  input  logic                 avs_write,
  input  logic [15:0]          avs_writedata,
  output logic [15:0]          avs_readdata,
  output logic                 avs_waitrequest,
  // Serial side.
  input  logic                 frame_pulse,
  input  logic [NSTREAM-1:0]   serial_in_stream,
  output logic [NSTREAM-1:0]   serial_out_stream
);

  localparam int DW = $clog2(DMAX);
  localparam logic [DW-1:0] ADV_STEP = DW'(`ADV_STEP_CYC);
  localparam logic [DW-1:0] ADV_MAX  = DW'(`ADV_STEP_CYC * `ADV_MAX_CODE);

  typedef struct packed {
    logic [1:0]           fp_sy;
    logic                 fp_d;
    logic [NSTREAM-1:0]   si_a;
    logic [NSTREAM-1:0]   si_b;
    logic [15:0]          ctrl;
    logic                 sfe_d;
    logic                 ev_in_d;
    eval_state_t          ev;
    logic [9:0]           hcnt;
    logic [7:0]           hdiv;
    logic [8:0]           fd;
    logic                 half;
    logic                 cfe;
    logic [NSTREAM*4-1:0] ioff;
    logic [NSTREAM*2-1:0] ooff;
    logic                 waitreq;
    logic [15:0]          rdata;
    logic [7:0]           dmrd;
    logic [7:0]           icyc;
    logic [7:0]           ocyc;
    logic [2:0]           ibit;
    logic [2:0]           obit;
    logic [7:0]           ich;
    logic [7:0]           och;
    logic                 page;
    logic                 sq_act;
    logic [4:0]           sq_idx;
    logic [7:0]           sq_ch;
    logic [NSTREAM*8-1:0] pend;
    logic [14:0]          prbs;
  } sw_st_t;

  sw_st_t               s;
  sw_st_t               n;
  logic [15:0]          cmem [0:NSTREAM*NCHAN-1];
  logic [NSTREAM*8-1:0] dmem [0:1][0:NCHAN-1];
  logic [1:0]           ir;
  logic [1:0]           orr;
  logic [7:0]           ibc;
  logic [7:0]           obc;
  logic [7:0]           imax;
  logic [7:0]           omax;
  logic                 adv_en;
  logic                 itick;
  logic                 otick;
  logic                 fp_edge;
  logic                 ev_in;
  logic                 ev_hit;
  logic                 sfe_rise;
  logic                 sfe_fall;
  logic                 ms;
  logic                 req;
  logic                 take;
  logic [15:0]          rd_val;
  logic [13:0]          ra_i;
  logic [13:0]          ra_o;
  logic [7:0]           dm_byte;
  logic [15:0]          cm_word;
  chan_mode_t           cm_mode;
  logic [NSTREAM*8-1:0] src_row;
  logic [7:0]           seq_byte;
  logic                 dm_wr;
  logic                 dm_pg;
  logic [7:0]           dm_ch;
  logic [NSTREAM*8-1:0] in_row;
  logic [DW-1:0]        idly [NSTREAM];
  logic [DW-1:0]        odly [NSTREAM];

  // ----------------------------------------------------------------------
  // Rate decode
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (s.ctrl[2:0])
      3'b000:  begin ir = 2'd2; orr = 2'd2; end
      3'b001:  begin ir = 2'd3; orr = 2'd3; end
      3'b010:  begin ir = 2'd1; orr = 2'd2; end
      3'b011:  begin ir = 2'd3; orr = 2'd2; end
      3'b100:  begin ir = 2'd1; orr = 2'd1; end
      3'b101:  begin ir = 2'd0; orr = 2'd1; end
      3'b110:  begin ir = 2'd0; orr = 2'd0; end
      default: begin ir = 2'd2; orr = 2'd2; end
    endcase
  end

  assign ibc    = 8'(BIT16_CYC) << (2'd3 - ir);
  assign obc    = 8'(BIT16_CYC) << (2'd3 - orr);
  assign imax   = 8'((`CH_AT_2M << ir) - 1);
  assign omax   = 8'((`CH_AT_2M << orr) - 1);
  assign adv_en = !s.ctrl[2];
  assign itick  = s.icyc == (ibc >> 1);
  assign otick  = s.ocyc == 8'h00;
  assign fp_edge = s.fp_sy[1] && !s.fp_d;

  // ----------------------------------------------------------------------
  // Serial lanes with per-stream offsets
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < NSTREAM; g++) begin : g_lane
    logic [3:0] icode;
    assign icode   = s.ioff[g*4 +: 4];
    assign idly[g] = DW'(((icode > 4'(`IN_MAX_CODE)) ? 4'(`IN_MAX_CODE) : icode)
                     * MCLK_HALF_CYC);
    assign odly[g] = adv_en ? DW'(ADV_MAX - DW'(s.ooff[g*2 +: 2]) * ADV_STEP)
                            : ADV_MAX;
    serial_lane #(.DMAX(DMAX)) u_lane (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_tick   (itick),
      .in_last   (itick && s.ibit == 3'h7),
      .in_dly    (idly[g]),
      .sin       (s.si_b[g]),
      .in_byte   (in_row[g*8 +: 8]),
      .out_tick  (otick),
      .out_first (s.obit == 3'h0),
      .out_dly   (odly[g]),
      .out_byte  (s.pend[g*8 +: 8]),
      .sout      (serial_out_stream[g])
    );
  end

  // ----------------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------------
  assign dm_wr = itick && s.ibit == `WR_BIT;
  assign dm_ch = (s.ich == 8'h00) ? imax : s.ich - 8'h01;
  assign dm_pg = s.page ^ (s.ich == 8'h00);

  always_ff @(posedge clk) begin
    if (dm_wr) dmem[dm_pg][dm_ch] <= in_row;
  end

  always_ff @(posedge clk) begin
    if (take && avs_write && avs_address[13] && !ms)
      cmem[avs_address[12:0]] <= avs_writedata;
  end

  // Constant delay reads last frame's page so delay does not vary.
  assign cm_word  = cmem[{s.sq_idx, s.sq_ch}];
  assign cm_mode  = chan_mode_t'({cm_word[`CM_MHI_BIT], cm_word[`CM_MLO_BIT]});
  assign src_row  = dmem[s.page ^ cm_word[`CM_MHI_BIT]][cm_word[7:0]];
  always_comb begin
    unique case (cm_mode)
      MODE_VAR, MODE_CONST: seq_byte = src_row[{cm_word[12:8], 3'b000} +: 8];
      MODE_MSG:             seq_byte = cm_word[7:0];
      MODE_BERT:            seq_byte = s.prbs[7:0];
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign ms   = s.ctrl[`CTRL_MS_BIT];
  assign req  = avs_read || avs_write;
  assign take = req && !s.waitreq;
  assign ra_i = avs_address - `IOFF_BASE;
  assign ra_o = avs_address - `OOFF_BASE;
  assign dm_byte = dmem[s.page][avs_address[7:0]][{avs_address[12:8], 3'b000} +: 8];

  always_comb begin
    rd_val = 16'h0000;
    if (avs_address[13]) begin
      rd_val = ms ? {8'h00, s.dmrd} : cmem[avs_address[12:0]];
    end else if (avs_address == `CTRL_ADDR) begin
      rd_val = s.ctrl;
    end else if (avs_address == `FAR_ADDR) begin
      rd_val = {5'h00, s.cfe, s.half, s.fd};
    end else if (ra_i < 14'(NSTREAM / 4)) begin
      rd_val = s.ioff[ra_i*16 +: 16];
    end else if (ra_o < 14'(NSTREAM / 8)) begin
      rd_val = s.ooff[ra_o*16 +: 16];
    end
  end

  assign ev_in  = s.si_b[s.ctrl[`CTRL_EVS_LSB +: 5]];
  assign ev_hit = s.ev_in_d && !ev_in;
  assign sfe_rise = s.ctrl[`CTRL_SFE_BIT] && !s.sfe_d;
  assign sfe_fall = !s.ctrl[`CTRL_SFE_BIT] && s.sfe_d;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = s;
    n.si_a  = serial_in_stream;
    n.si_b  = s.si_a;
    n.fp_sy = {s.fp_sy[0], frame_pulse};
    n.fp_d  = s.fp_sy[1];
    n.sfe_d = s.ctrl[`CTRL_SFE_BIT];
    n.ev_in_d = ev_in;
    // Output timer runs ADV_MAX cycles early; lanes delay it back.
    if (fp_edge) begin
      n.icyc = 8'h00;
      n.ibit = 3'h0;
      n.ich  = 8'h00;
      n.ocyc = 8'(ADV_MAX);
      n.obit = 3'h0;
      n.och  = 8'h00;
      n.page = !s.page;
    end else begin
      n.icyc = (s.icyc == ibc - 8'h01) ? 8'h00 : s.icyc + 8'h01;
      if (s.icyc == ibc - 8'h01) begin
        n.ibit = s.ibit + 3'h1;
        if (s.ibit == 3'h7) n.ich = (s.ich == imax) ? 8'h00 : s.ich + 8'h01;
      end
      n.ocyc = (s.ocyc == obc - 8'h01) ? 8'h00 : s.ocyc + 8'h01;
      if (s.ocyc == obc - 8'h01) begin
        n.obit = s.obit + 3'h1;
        if (s.obit == 3'h7) n.och = (s.och == omax) ? 8'h00 : s.och + 8'h01;
      end
    end
    // Fetch next channel's bytes for every output stream.
    if (otick && s.obit == `SQ_BIT) begin
      n.sq_act = 1'b1;
      n.sq_idx = 5'h00;
      n.sq_ch  = (s.och == omax) ? 8'h00 : s.och + 8'h01;
    end else if (s.sq_act) begin
      n.pend[s.sq_idx*8 +: 8] = seq_byte;
      if (cm_mode == MODE_BERT)
        n.prbs = {s.prbs[13:0], s.prbs[14] ^ s.prbs[13]};
      n.sq_idx = s.sq_idx + 5'h01;
      if (s.sq_idx == 5'(NSTREAM - 1)) n.sq_act = 1'b0;
    end
    // Frame offset measurement in half master-clock units.
    unique case (s.ev)
      EV_IDLE: if (sfe_rise) n.ev = EV_WAIT;
      EV_WAIT: begin
        if (fp_edge) begin
          n.ev   = EV_CNT;
          n.hcnt = 10'h000;
          n.hdiv = 8'h00;
        end
      end
      EV_CNT: begin
        n.hdiv = (s.hdiv == 8'(MCLK_HALF_CYC - 1)) ? 8'h00 : s.hdiv + 8'h01;
        if (s.hdiv == 8'(MCLK_HALF_CYC - 1)) n.hcnt = s.hcnt + 10'h001;
        if (ev_hit || s.hcnt == 10'h3FF) begin
          n.fd   = s.hcnt[9:1];
          n.half = !s.hcnt[0];
          n.cfe  = 1'b1;
          n.ev   = EV_DONE;
        end
      end
      EV_DONE: n.ev = EV_DONE;
    endcase
    if (sfe_fall) begin
      n.fd   = 9'h000;
      n.half = 1'b0;
      n.cfe  = 1'b0;
      n.ev   = EV_IDLE;
    end
    // Bus slave: one wait cycle, then the access completes.
    n.waitreq = 1'b1;
    if (req && s.waitreq) begin
      n.waitreq = 1'b0;
      if (avs_read) begin
        n.rdata = rd_val;
        if (avs_address[13] && ms) n.dmrd = dm_byte;
      end
    end
    if (take && avs_write && !avs_address[13]) begin
      if (avs_address == `CTRL_ADDR) n.ctrl = avs_writedata;
      else if (ra_i < 14'(NSTREAM / 4)) n.ioff[ra_i*16 +: 16] = avs_writedata;
      else if (ra_o < 14'(NSTREAM / 8)) n.ooff[ra_o*16 +: 16] = avs_writedata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s         <= '0;
      s.ctrl    <= `CTRL_RST;
      s.waitreq <= 1'b1;
      s.prbs    <= `PRBS_SEED;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.waitreq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic [12:0] cm_a;
  logic [7:0]  cm_lo;
  assign cm_a  = avs_address[12:0];
  assign cm_lo = cm_word[7:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_fd_value;
    (s.ev == EV_CNT && ev_hit && !sfe_fall) |=>
      s.cfe && s.fd == 9'($past(s.hcnt) >> 1) && s.half == !$past(s.hcnt[0]);
  endproperty
  a_fd_value: assert property (p_fd_value) else $error("Delay field wrong.");

  property p_fd_clear;
    $fell(s.ctrl[`CTRL_SFE_BIT]) |=> s.fd == 9'h000 && !s.cfe && s.ev == EV_IDLE;
  endproperty
  a_fd_clear: assert property (p_fd_clear) else $error("Delay not cleared.");

  property p_eval_start;
    (s.ev == EV_IDLE && sfe_rise) |=> s.ev == EV_WAIT ##1 (s.ev != EV_DONE);
  endproperty
  a_eval_start: assert property (p_eval_start) else $error("Eval not begun.");

  property p_adv_off;
    !adv_en |-> odly[0] == ADV_MAX && odly[NSTREAM-1] == ADV_MAX;
  endproperty
  a_adv_off: assert property (p_adv_off) else $error("Advance in slow mode.");

  property p_adv_step;
    (adv_en && s.ooff[1:0] == 2'b11) |-> odly[0] == DW'(0);
  endproperty
  a_adv_step: assert property (p_adv_step) else $error("Advance step wrong.");

  property p_cm_wr;
    (take && avs_write && avs_address[13] && !ms) |=>
      cmem[$past(cm_a)] == $past(avs_writedata);
  endproperty
  a_cm_wr: assert property (p_cm_wr) else $error("Connection write lost.");

  property p_msg;
    (s.sq_act && cm_mode == MODE_MSG) |=> s.pend[8*$past(s.sq_idx) +: 8] == $past(cm_lo);
  endproperty
  a_msg: assert property (p_msg) else $error("Message byte wrong.");

  property p_rate16;
    (s.ctrl[2:0] == 3'b001) |-> ibc == 8'(BIT16_CYC) && imax == 8'hFF && omax == 8'hFF;
  endproperty
  a_rate16: assert property (p_rate16) else $error("Rate decode wrong.");

  property p_dm_read;
    (req && s.waitreq && avs_read && avs_address[13] && ms) |=>
      !s.waitreq && s.rdata == {8'h00, $past(s.dmrd)};
  endproperty
  a_dm_read: assert property (p_dm_read) else $error("Stale read wrong.");

  c_eval_done: cover property (s.ev == EV_CNT ##1 s.ev == EV_DONE);
  c_bert:      cover property (s.sq_act && cm_mode == MODE_BERT);
  c_dm_read:   cover property (take && avs_read && avs_address[13] && ms);

endmodule : tdm_switch

// >>> sim/host_model.sv
/*
  Host processor model: Avalon-MM master with one word read/write task.
  Assumes a slave that lowers waitrequest for one cycle per access.
*/
`timescale 1ns/1ps
module host_model (
  // Clock.
  input  wire logic        clk,
  // Avalon-MM master side.
  output logic [13:0] address,
  output logic        read,
  output logic        write,
  output logic [15:0] writedata,
  input  wire logic [15:0] readdata,
  input  wire logic        waitrequest
);
  initial begin
    address   = 14'h0000;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 16'h0000;
  end

  // One access held until waitrequest is sampled low at a rising edge.
  task automatic xfer(input logic w, input logic [13:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    read      <= !w;
    write     <= w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : xfer
endmodule : host_model

// >>> sim/tb_top.sv
/*
  Self-checking bench for the switch core at 16 Mbps.
  Assumes the design's register map, one wait state and reset as noted.
*/
`timescale 1ns/1ps
`include "tdm_switch_defs.svh"
module tb_top;
  import tdm_switch_pkg::*;
  localparam int FRAME = 256 * 8 * 12;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        fp = 1'b0;
  logic [31:0] sin = 32'h0000_0006;
  logic [31:0] sout;
  logic [13:0] adr;
  logic        rd, wr, wq;
  logic [15:0] wd, rdat, q;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  initial forever #2.5 clk = ~clk;

  host_model host (.clk(clk), .address(adr), .read(rd), .write(wr), .writedata(wd),
                   .readdata(rdat), .waitrequest(wq));
  tdm_switch dut (.clk(clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd),
                  .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
                  .avs_waitrequest(wq), .frame_pulse(fp), .serial_in_stream(sin),
                  .serial_out_stream(sout));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input string n, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : check

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic w16(input logic [13:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : w16

  task automatic r16(input logic [13:0] a);
    host.xfer(1'b0, a, 16'h0000, q);
  endtask : r16

  // Frame pulse every frame once reset is released.
  initial begin
    @(posedge reset_n);
    forever begin
      @(posedge clk);
      fp <= 1'b1;
      @(posedge clk);
      fp <= 1'b0;
      repeat (FRAME - 2) @(posedge clk);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    r16(`CTRL_ADDR);
    check("control reset", q, `CTRL_RST);
    r16(`FAR_ADDR);
    check("align reset", q, 16'h0000);
    r16(14'h0100);
    check("unmapped read", q, 16'h0000);
  endtask : t_reset

  task automatic t_regs();
    w16(`CTRL_ADDR, 16'h0001);
    r16(`CTRL_ADDR);
    check("rate select", q, 16'h0001);
    w16(`IOFF_BASE + 14'h0001, 16'h9531);
    r16(`IOFF_BASE + 14'h0001);
    check("input offsets", q, 16'h9531);
    r16(`IOFF_BASE);
    check("other input offsets", q, 16'h0000);
    w16(`OOFF_BASE, 16'h00E7);
    r16(`OOFF_BASE);
    check("output advance", q, 16'h00E7);
    w16(`CTRL_ADDR, 16'h0004);
    r16(`CTRL_ADDR);
    check("slow rate select", q, 16'h0004);
    w16(`CTRL_ADDR, 16'h0001);
  endtask : t_regs

  task automatic t_dmem();
    w16(`CTRL_ADDR, 16'h0009);
    // Let the current frame store channel 5 on its page before it is read.
    repeat (FRAME / 2) @(posedge clk);
    r16(14'h2105);
    r16(14'h2105);
    check("data mem stream 1", q, 16'h00FF);
    r16(14'h2005);
    r16(14'h2005);
    check("data mem stream 0", q, 16'h0000);
  endtask : t_dmem

  // Output streams are sampled once a bit; streams 3, 4 and 6 are searched for a byte, stream 5 for a one.
  task automatic t_conn();
    logic [7:0] sr [8];
    logic [7:0] hit;
    hit = 8'h00;
    w16(`CTRL_ADDR, 16'h0001);
    w16(14'h2307, 16'h205A);
    w16(14'h2409, 16'h0105);
    w16(14'h2609, 16'h4105);
    w16(14'h2502, 16'h6000);
    for (int i = 0; i < 8; i++) sr[i] = 8'h00;
    for (int b = 0; b < 3072; b++) begin
      repeat (12) @(posedge clk);
      for (int s = 3; s < 7; s++) sr[s] = {sr[s][6:0], sout[s]};
      if (sr[3] === 8'h5A) hit[3] = 1'b1;
      if (sr[4] === 8'hFF) hit[4] = 1'b1;
      if (sout[5] === 1'b1) hit[5] = 1'b1;
      if (sr[6] === 8'hFF) hit[6] = 1'b1;
    end
    check("message byte", {15'h0, hit[3]}, 16'h0001);
    check("variable switch", {15'h0, hit[4]}, 16'h0001);
    check("test pattern", {15'h0, hit[5]}, 16'h0001);
    check("constant switch", {15'h0, hit[6]}, 16'h0001);
  endtask : t_conn

  task automatic t_meas();
    int          n;
    logic [15:0] code;
    n = 0;
    w16(`CTRL_ADDR, 16'h1109);
    @(posedge fp);
    repeat (60) @(posedge clk);
    sin[2] <= 1'b0;
    do begin
      r16(`FAR_ADDR);
      n++;
    end while (q[`FAR_CFE_BIT] !== 1'b1 && n < 50);
    check("eval complete", {15'h0, q[`FAR_CFE_BIT]}, 16'h0001);
    check("delay nonzero", {15'h0, q[8:0] != 9'h000}, 16'h0001);
    code = {12'h000, q[2:0], ~q[`FAR_HALF_BIT]};
    w16(`IOFF_BASE, code);
    r16(`IOFF_BASE);
    check("derived offset", q, code);
    w16(`CTRL_ADDR, 16'h0009);
    r16(`FAR_ADDR);
    check("align cleared", q, 16'h0000);
  endtask : t_meas

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_dmem();
    t_conn();
    t_meas();
    stop_test();
  end
endmodule : tb_top
